// file: mbs_memory_board.sv
// Memory-board slave answering asynchronous processor bus cycles, with APB status
//
// Operation
// - Ignore cycle while cpu-space line is low
// - Data valid on bus before primary acknowledge
// - Data taken before primary acknowledge
// - Acknowledge pair encodes 32-bit or 8-bit port
// - Programming supply on only while flash enabled
// - Memory reset clears all board logic; here the stored words and the latched last address are kept
// - Low address bits and size give lanes
// - Cycle starts on address strobe low
// - Read/write line high read, low write
// - Size lines encode 8/16/24/32 bits
// - Module strobe low only with valid address
// - Option RAM select low enables module RAM
// - Guard low on reset or low supply
//
// The APB interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module mbs_memory_board #(
	parameter int DEPTH = 16
) (
	input  wire logic                          pclk,
	input  wire logic                          presetn,
	input  wire logic                          psel,
	input  wire logic                          penable,
	input  wire logic                          pwrite,
	input  wire logic [7:0]                    paddr,
	input  wire logic [31:0]                   pwdata,
	output logic      [31:0]                   prdata,
	output logic                               pready,
	output logic                               pslverr,
	input  wire logic                          board_reset,
	input  wire logic                          supply_low,
	input  wire logic                          flash_program_enable,
	output logic                               flash_vpp_on,
	input  wire logic                          cpu_space_cycle_n,
	input  wire logic                          proc_addr_strobe_n,
	input  wire logic                          proc_read_not_write,
	input  wire logic                          operand_size_lo,
	input  wire logic                          operand_size_hi,
	input  wire logic [mbs_pkg::MBS_PA_W-1:0]  proc_addr,
	input  wire logic [15:0]                   proc_data_low_i,
	output logic      [15:0]                   proc_data_low_o,
	input  wire logic [15:0]                   buffered_data_high_i,
	output logic      [15:0]                   buffered_data_high_o,
	output logic                               data_oe,
	output logic                               cycle_ack_primary_n,
	output logic                               cycle_ack_secondary_n,
	output logic                               module_addr_strobe_n,
	output logic      [mbs_pkg::MBS_MA_W-1:0]  module_addr,
	input  wire logic [7:0]                    module_data_i,
	output logic      [7:0]                    module_data_o,
	output logic                               module_data_oe,
	output logic                               option_ram_select_n,
	output logic                               ram_write_guard_n,
	input  wire logic                          module_present_n
);
	import mbs_pkg::*;

	localparam int IW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	typedef struct packed {
		mbs_cycle_e                 st;
		logic [DEPTH-1:0][31:0]     mem;
		logic [MBS_CTRL_W-1:0]      ctrl;
		logic [MBS_PA_W-1:0]        addr;
		logic                       rd;
		logic                       opt;
		logic [3:0]                 lanes;
		logic [31:0]                dout;
		logic                       data_oe;
		logic                       ack_p_n;
		logic                       ack_s_n;
		logic                       mas_n;
		logic [MBS_MA_W-1:0]        maddr;
		logic [7:0]                 mdout;
		logic                       mdata_oe;
		logic                       sel_n;
		logic                       guard_n;
		logic                       vpp_on;
		logic [31:0]                cycles;
		logic [31:0]                prdata;
		logic                       pready;
		logic                       pslverr;
	} mbs_state_s;

	mbs_state_s s;
	mbs_state_s n;

	// Bytes touched, lane 0 being bits 31:24; transfers past the word end are clipped
	function automatic logic [3:0] mbs_lane_mask(input logic [1:0] a, input logic [1:0] sz);
		logic [2:0] cnt;
		logic [3:0] m;
		cnt = (sz == MBS_SZ_32) ? MBS_BYTES_32 : {1'b0, sz};
		m = 4'h0;
		for (int i = 0; i < 4; i++) begin
			m[i] = (3'(i) >= {1'b0, a}) && (3'(i) < ({1'b0, a} + cnt));
		end
		return m;
	endfunction

	function automatic logic [IW-1:0] mbs_index(input logic [MBS_PA_W-1:0] a);
		return a[IW+1:2];
	endfunction

	logic [31:0] bus_wdata;
	assign bus_wdata = {buffered_data_high_i, proc_data_low_i};

	////////////////////////////////////////////////////////////////////////////
	always_comb begin
		n = s;
		n.pready  = 1'b0;
		n.pslverr = 1'b0;

		// APB: one wait state, answer registered
		if (psel && penable && !s.pready) begin
			n.pready = 1'b1;
			case (paddr)
				MBS_OFS_CTRL: begin
					if (pwrite) begin
						n.ctrl = pwdata[MBS_CTRL_W-1:0];
					end
					n.prdata = {30'h0, s.ctrl};
				end
				MBS_OFS_STATUS: begin
					n.prdata = 32'h0;
					n.prdata[MBS_ST_PRESENT] = !module_present_n;
					n.prdata[MBS_ST_FLASH]   = s.vpp_on;
					n.prdata[MBS_ST_GUARD]   = s.guard_n;
					n.prdata[MBS_ST_BUSY]    = (s.st != MBS_IDLE);
				end
				MBS_OFS_CYCLES: begin
					n.prdata = s.cycles;
				end
				MBS_OFS_LAST_ADDR: begin
					n.prdata = {5'h0, s.addr};
				end
				default: begin
					n.prdata  = 32'h0;
					n.pslverr = 1'b1;
				end
			endcase
		end

		n.vpp_on  = flash_program_enable && !board_reset;
		n.guard_n = !(board_reset || supply_low);

		case (s.st)
			MBS_IDLE: begin
				// Cpu-space cycles belong to another responder
				if (!proc_addr_strobe_n && cpu_space_cycle_n && s.ctrl[MBS_CTRL_RESPOND]) begin
					n.addr  = proc_addr;
					n.rd    = proc_read_not_write;
					n.opt   = proc_addr[MBS_OPT_SEL_BIT] && s.ctrl[MBS_CTRL_OPT_EN];
					n.lanes = mbs_lane_mask(proc_addr[1:0], {operand_size_hi, operand_size_lo});
					n.st    = MBS_LATCH;
					if (proc_addr[MBS_OPT_SEL_BIT] && s.ctrl[MBS_CTRL_OPT_EN]) begin
						n.maddr = proc_addr[MBS_MA_W-1:0];
						n.mas_n = 1'b0;
						n.sel_n = 1'b0;
					end
				end
			end
			MBS_LATCH: begin
				if (s.rd && !s.opt) begin
					n.dout    = s.mem[mbs_index(s.addr)];
					n.data_oe = 1'b1;
				end else if (!s.rd && s.opt) begin
					n.mdout    = buffered_data_high_i[15:8];
					n.mdata_oe = 1'b1;
				end
				n.st = MBS_XFER;
			end
			MBS_XFER: begin
				if (s.rd && !s.data_oe) begin
					// Module byte comes back on the top lane only
					n.dout    = {module_data_i, 24'h0};
					n.data_oe = 1'b1;
				end else begin
					if (!s.rd && !s.opt) begin
						for (int i = 0; i < 4; i++) begin
							if (s.lanes[i]) begin
								n.mem[mbs_index(s.addr)][31-8*i -: 8] = bus_wdata[31-8*i -: 8];
							end
						end
					end
					n.ack_p_n = 1'b0;
					n.ack_s_n = s.opt;
					n.cycles  = s.cycles + 32'h1;
					n.st      = MBS_ACK;
				end
				if (proc_addr_strobe_n) begin
					// Aborted cycle: drop everything without answering
					n.ack_p_n  = 1'b1;
					n.ack_s_n  = 1'b1;
					n.data_oe  = 1'b0;
					n.mdata_oe = 1'b0;
					n.mas_n    = 1'b1;
					n.sel_n    = 1'b1;
					n.cycles   = s.cycles;
					n.mem      = s.mem;
					n.st       = MBS_IDLE;
				end
			end
			MBS_ACK: begin
				if (proc_addr_strobe_n) begin
					n.ack_p_n  = 1'b1;
					n.ack_s_n  = 1'b1;
					n.data_oe  = 1'b0;
					n.mdata_oe = 1'b0;
					n.mas_n    = 1'b1;
					n.sel_n    = 1'b1;
					n.st       = MBS_IDLE;
				end
			end
			default: begin
				n.st = MBS_IDLE;
			end
		endcase

		// Memory reset clears the control path; stored words survive like real RAM
		if (board_reset) begin
			n.st       = MBS_IDLE;
			n.ctrl     = MBS_CTRL_RST;
			n.ack_p_n  = 1'b1;
			n.ack_s_n  = 1'b1;
			n.data_oe  = 1'b0;
			n.mdata_oe = 1'b0;
			n.mas_n    = 1'b1;
			n.sel_n    = 1'b1;
			n.cycles   = 32'h0;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s         <= '0;
			s.st      <= MBS_IDLE;
			s.ctrl    <= MBS_CTRL_RST;
			s.ack_p_n <= 1'b1;
			s.ack_s_n <= 1'b1;
			s.mas_n   <= 1'b1;
			s.sel_n   <= 1'b1;
		end else begin
			s <= n;
		end
	end

	assign prdata                = s.prdata;
	assign pready                = s.pready;
	assign pslverr               = s.pslverr;
	assign flash_vpp_on          = s.vpp_on;
	assign proc_data_low_o       = s.dout[15:0];
	assign buffered_data_high_o  = s.dout[31:16];
	assign data_oe               = s.data_oe;
	assign cycle_ack_primary_n   = s.ack_p_n;
	assign cycle_ack_secondary_n = s.ack_s_n;
	assign module_addr_strobe_n  = s.mas_n;
	assign module_addr           = s.maddr;
	assign module_data_o         = s.mdout;
	assign module_data_oe        = s.mdata_oe;
	assign option_ram_select_n   = s.sel_n;
	assign ram_write_guard_n     = s.guard_n;

	////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_ack_low;
		!s.ack_p_n;
	endsequence

	sequence s_strobe_up;
		proc_addr_strobe_n ##1 1'b1;
	endsequence

	property p_cpu_space_ignored;
		(s.st == MBS_IDLE && !cpu_space_cycle_n) |=> (s.st == MBS_IDLE && s.ack_p_n && !s.data_oe);
	endproperty
	a_cpu_space_ignored: assert property (p_cpu_space_ignored) else $error("cpu-space cycle answered");

	property p_read_data_first;
		($fell(s.ack_p_n) && s.rd) |-> (s.data_oe && $past(s.data_oe));
	endproperty
	a_read_data_first: assert property (p_read_data_first) else $error("read ack before data valid");

	property p_write_taken_first;
		($fell(s.ack_p_n) && !s.rd) |-> ($past(s.st, 2) == MBS_LATCH && $past(s.st) == MBS_XFER);
	endproperty
	a_write_taken_first: assert property (p_write_taken_first) else $error("write ack without take phase");

	property p_port_width;
		s_ack_low |-> (s.ack_s_n == s.opt);
	endproperty
	a_port_width: assert property (p_port_width) else $error("ack pair gives wrong port width");

	property p_flash_supply;
		##1 (s.vpp_on == $past(flash_program_enable && !board_reset));
	endproperty
	a_flash_supply: assert property (p_flash_supply) else $error("programming supply mismatch");

	property p_board_reset;
		board_reset |=> (s.st == MBS_IDLE && s.ack_p_n && s.ack_s_n && !s.data_oe && s.mas_n);
	endproperty
	a_board_reset: assert property (p_board_reset) else $error("memory reset left logic active");

	property p_module_strobe;
		!s.mas_n |-> (s.opt && s.st != MBS_IDLE && s.maddr == s.addr[MBS_MA_W-1:0]);
	endproperty
	a_module_strobe: assert property (p_module_strobe) else $error("module strobe without valid address");

	property p_select;
		!s.sel_n |-> (s.opt && !s.mas_n);
	endproperty
	a_select: assert property (p_select) else $error("option ram selected outside module cycle");

	property p_guard;
		(board_reset || supply_low) |=> !s.guard_n;
	endproperty
	a_guard: assert property (p_guard) else $error("guard not asserted");

	property p_ack_release;
		(s_ack_low ##0 s_strobe_up) |-> (s.ack_p_n && s.ack_s_n);
	endproperty
	a_ack_release: assert property (p_ack_release) else $error("ack held after strobe rose");

	property p_ack_holds;
		(s_ack_low ##0 !proc_addr_strobe_n) |=> (!s.ack_p_n || $past(board_reset));
	endproperty
	a_ack_holds: assert property (p_ack_holds) else $error("ack dropped while strobe low");

	property p_lanes;
		(s.st == MBS_IDLE && $changed(s.st) == 1'b0 && n.st == MBS_LATCH)
			|=> (s.lanes == mbs_lane_mask(s.addr[1:0], $past({operand_size_hi, operand_size_lo})));
	endproperty
	a_lanes: assert property (p_lanes) else $error("byte lanes wrong");

endmodule

// file: mbs_pkg.sv
// Constants, register map and state codes for the memory-board bus slave
package mbs_pkg;

	// APB register byte offsets
	localparam logic [7:0] MBS_OFS_CTRL      = 8'h00;
	localparam logic [7:0] MBS_OFS_STATUS    = 8'h04;
	localparam logic [7:0] MBS_OFS_CYCLES    = 8'h08;
	localparam logic [7:0] MBS_OFS_LAST_ADDR = 8'h0c;

	// Control fields
	localparam int         MBS_CTRL_W          = 2;
	localparam int         MBS_CTRL_RESPOND    = 0;
	localparam int         MBS_CTRL_OPT_EN     = 1;
	localparam logic [1:0] MBS_CTRL_RST        = 2'h3;

	// Status fields
	localparam int MBS_ST_PRESENT = 0;
	localparam int MBS_ST_FLASH   = 1;
	localparam int MBS_ST_GUARD   = 2;
	localparam int MBS_ST_BUSY    = 3;

	// Address layout
	localparam int MBS_PA_W        = 27;
	localparam int MBS_MA_W        = 22;
	localparam int MBS_OPT_SEL_BIT = 26;

	// Operand size codes {size_hi, size_lo}
	localparam logic [1:0] MBS_SZ_32 = 2'h0;
	localparam logic [2:0] MBS_BYTES_32 = 3'h4;

	typedef enum logic [3:0] {
		MBS_IDLE  = 4'h1,
		MBS_LATCH = 4'h2,
		MBS_XFER  = 4'h4,
		MBS_ACK   = 4'h8
	} mbs_cycle_e;

endpackage

// file: mbs_host_model.sv
// Host processor model that runs asynchronous bus cycles against the board
`timescale 1ns/1ps
module mbs_host_model (
	input  wire logic        clk,
	input  wire logic [15:0] lo_o,
	input  wire logic [15:0] hi_o,
	input  wire logic        ack_p_n,
	input  wire logic        ack_s_n,
	input  wire logic        oe,
	output logic             as_n,
	output logic             cs_n,
	output logic             rw,
	output logic             sz_lo,
	output logic             sz_hi,
	output logic [26:0]      addr,
	output logic [15:0]      lo_i,
	output logic [15:0]      hi_i
);
	logic [31:0] wd;
	logic        drv;
	// Undriven bus shows the inverse, so a missing output enable is caught
	assign lo_i = drv ? wd[15:0] : (oe ? lo_o : ~lo_o);
	assign hi_i = drv ? wd[31:16] : (oe ? hi_o : ~hi_o);
	initial begin
		as_n = 1;
		cs_n = 1;
		rw = 1;
		{sz_hi, sz_lo} = 2'h0;
		addr = 0;
		wd = 0;
		drv = 0;
	end
	////////////////////////////////////////////////////////////////
	task automatic cycle(input logic r, input logic [1:0] sz, input logic [26:0] a, input logic [31:0] d,
		input logic sp_n, output logic [31:0] rd, output logic [1:0] ack, output logic rel);
		rd = 0;
		ack = 2'h3;
		rel = 0;
		@(posedge clk);
		addr <= a;
		rw <= r;
		{sz_hi, sz_lo} <= sz;
		cs_n <= sp_n;
		wd <= d;
		drv <= !r;
		as_n <= 0;
		// Bounded wait; no answer at all is a legal outcome here
		for (int i = 0; i < 12 && ack == 2'h3; i++) begin
			@(posedge clk);
			if (ack_p_n === 1'b0) begin
				ack = {ack_s_n, ack_p_n};
				rd = oe ? {hi_o, lo_o} : ~{hi_o, lo_o};
			end
		end
		as_n <= 1;
		drv <= 0;
		for (int i = 0; i < 6 && !rel; i++) begin
			@(posedge clk);
			rel = ack_p_n & ack_s_n;
		end
		cs_n <= 1;
	endtask
endmodule

// file: mbs_memory_board_tb.sv
// Self-checking bench for the memory-board bus slave
`timescale 1ns/1ps
module mbs_memory_board_tb;
	import mbs_pkg::*;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, board_reset, supply_low, flash_program_enable;
	logic        flash_vpp_on, cs_n, as_n, rw, sz_lo, sz_hi, data_oe, ack_p_n, ack_s_n, mas_n, mdoe, sel_n, guard_n;
	logic        rl, er, present_n;
	logic [1:0]  ak;
	logic [7:0]  paddr, module_data_i, mdo, mod_byte;
	logic [31:0] pwdata, prdata, rd;
	logic [26:0] pa;
	logic [15:0] lo_i, lo_o, hi_i, hi_o;
	logic [21:0] maddr, sel_addr;
	int          miscompares, comparisons;
	assign module_data_i = (!sel_n && rw) ? 8'h5a : ~mdo;
	mbs_memory_board DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.board_reset(board_reset), .supply_low(supply_low), .flash_program_enable(flash_program_enable),
		.flash_vpp_on(flash_vpp_on), .cpu_space_cycle_n(cs_n), .proc_addr_strobe_n(as_n),
		.proc_read_not_write(rw), .operand_size_lo(sz_lo), .operand_size_hi(sz_hi), .proc_addr(pa),
		.proc_data_low_i(lo_i), .proc_data_low_o(lo_o), .buffered_data_high_i(hi_i),
		.buffered_data_high_o(hi_o), .data_oe(data_oe), .cycle_ack_primary_n(ack_p_n),
		.cycle_ack_secondary_n(ack_s_n), .module_addr_strobe_n(mas_n), .module_addr(maddr),
		.module_data_i(module_data_i), .module_data_o(mdo), .module_data_oe(mdoe),
		.option_ram_select_n(sel_n), .ram_write_guard_n(guard_n), .module_present_n(present_n));
	mbs_host_model host (.clk(pclk), .lo_o(lo_o), .hi_o(hi_o), .oe(data_oe), .ack_p_n(ack_p_n), .ack_s_n(ack_s_n),
		.as_n(as_n), .cs_n(cs_n), .rw(rw), .sz_lo(sz_lo), .sz_hi(sz_hi), .addr(pa), .lo_i(lo_i), .hi_i(hi_i));
	////////////////////////////////////////////////////////////////
	initial begin
		pclk = 0;
		forever #2.5 pclk = ~pclk;
	end
	always @(posedge pclk) begin
		if (mas_n === 1'b0 && sel_n === 1'b0) begin
			sel_addr <= maddr;
		end
		if (mdoe === 1'b1) begin
			mod_byte <= mdo;
		end
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic end_of_test;
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1;
		for (n = 0; n < 20; n++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (n == 20) begin
			miscompares++;
			end_of_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		presetn = 1'b0;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		{board_reset, supply_low, flash_program_enable, present_n} = '0;
		{miscompares, comparisons} = 0;
		sel_addr = 22'h3fffff;
		mod_byte = 8'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, MBS_OFS_CTRL, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, MBS_OFS_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h5);
		host.cycle(1'b0, MBS_SZ_32, 27'h10, 32'h1234_5678, 1'b1, rd, ak, rl);
		chk(32'({ak, rl}), 32'h1);
		host.cycle(1'b0, 2'h3, 27'h11, 32'h0098_7654, 1'b1, rd, ak, rl);
		host.cycle(1'b0, 2'h1, 27'h11, 32'habab_abab, 1'b1, rd, ak, rl);
		host.cycle(1'b0, 2'h2, 27'h12, 32'hcdef_cdef, 1'b1, rd, ak, rl);
		host.cycle(1'b1, MBS_SZ_32, 27'h10, 32'h0, 1'b1, rd, ak, rl);
		chk(rd, 32'h12ab_cdef);
		// Space cycles must stay silent even with a valid address
		host.cycle(1'b1, MBS_SZ_32, 27'h10, 32'h0, 1'b0, rd, ak, rl);
		chk(32'({ak, rl}), 32'h7);
		host.cycle(1'b0, 2'h1, 27'h400_0004, 32'hc3c3_c3c3, 1'b1, rd, ak, rl);
		chk(32'({ak, rl}), 32'h5);
		chk(32'(mod_byte), 32'hc3);
		chk(32'(sel_addr), 32'h4);
		host.cycle(1'b1, 2'h1, 27'h400_0004, 32'h0, 1'b1, rd, ak, rl);
		chk(32'(rd[31:24]), 32'h5a);
		apb(1'b0, MBS_OFS_LAST_ADDR, 32'h0);
		chk(rd, 32'h0400_0004);
		apb(1'b0, MBS_OFS_CYCLES, 32'h0);
		chk(rd, 32'h7);
		// Module window closed: an address with bit 26 set is answered as a 32-bit port
		apb(1'b1, MBS_OFS_CTRL, 32'h1);
		host.cycle(1'b0, 2'h1, 27'h400_0008, 32'h7700_0000, 1'b1, rd, ak, rl);
		chk(32'({ak, rl}), 32'h1);
		chk(32'(sel_addr), 32'h4);
		flash_program_enable <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(flash_vpp_on), 32'h1);
		apb(1'b0, MBS_OFS_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h7);
		board_reset <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'({flash_vpp_on, guard_n}), 32'h0);
		board_reset <= 1'b0;
		flash_program_enable <= 1'b0;
		apb(1'b0, MBS_OFS_CTRL, 32'h0);
		chk(rd, 32'h3);
		apb(1'b0, MBS_OFS_CYCLES, 32'h0);
		chk(rd, 32'h0);
		// Responder switched off: no answer at all
		apb(1'b1, MBS_OFS_CTRL, 32'h0);
		host.cycle(1'b0, MBS_SZ_32, 27'h10, 32'h5555_5555, 1'b1, rd, ak, rl);
		chk(32'({ak, rl}), 32'h7);
		present_n <= 1'b1;
		supply_low <= 1'b1;
		repeat (3) @(posedge pclk);
		chk(32'(guard_n), 32'h0);
		apb(1'b0, MBS_OFS_STATUS, 32'h0);
		chk(rd & 32'h7, 32'h0);
		supply_low <= 1'b0;
		apb(1'b1, 8'h20, 32'h1);
		chk(rd, 32'h0);
		chk(32'(er), 32'h1);
		end_of_test();
	end
endmodule
